// File: hw/atsd_pkg.sv
`default_nettype none

package atsd_pkg;

  // ----------------------------------------------------------------
  // bus-cycle timing of snoop responses
  // ----------------------------------------------------------------
  localparam int             CNT_W          = 3;    // bus-cycle counters
  localparam logic [CNT_W-1:0] CNT_ONE      = 3'h1; // counter start value
  localparam logic [CNT_W-1:0] RTY_ASSERT_CYC = 3'h3; // after transfer start
  localparam logic [CNT_W-1:0] RTY_NEG_CYC  = 3'h2; // after address ack

  // ----------------------------------------------------------------
  // release phases of the shared response lines, in mclk cycles
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] FLOAT_CYC    = 3'h1; // first float step
  localparam logic [CNT_W-1:0] DRV_CYC_1_1  = 3'h1; // drive-high, 1:1
  localparam logic [CNT_W-1:0] DRV_CYC_2_1  = 3'h2; // drive-high, 2:1
  localparam logic [CNT_W-1:0] DRV_CYC_3_1  = 3'h2; // drive-high, 3:1
  localparam logic [CNT_W-1:0] DRV_CYC_3_2  = 3'h2; // drive-high, 3:2

  // ----------------------------------------------------------------
  // configuration word
  // ----------------------------------------------------------------
  localparam int CFG_W           = 32; // hardware implementation word
  localparam int RESTORE_DIS_BIT = 7;  // skip the drive-high step

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ATSD_RATIO_1_1,
    ATSD_RATIO_2_1,
    ATSD_RATIO_3_1,
    ATSD_RATIO_3_2
  } atsd_ratio_type;

  typedef enum logic [1:0] {
    OWN_IDLE,  // not address master
    OWN_ADDR,  // driving address, waiting for ack
    OWN_RTY    // bus cycle after ack: retry window
  } atsd_own_type;

  typedef enum logic [1:0] {
    DRV_OFF,   // lines floating
    DRV_ASRT,  // driving low
    DRV_FLOAT, // short float before restore
    DRV_HIGH   // driving negated
  } atsd_drv_type;

endpackage

`default_nettype wire

// File: hw/atsd_resp_if.sv
`default_nettype none

// ------------------------------------------------------------------
// snoop response control between sequencer and pin driver
// ------------------------------------------------------------------
interface atsd_resp_if;
  import atsd_pkg::*;
  logic           start;       // begin driving the response
  logic           neg;         // begin the release sequence
  logic           retry_val;   // drive retry low
  logic           shared_val;  // drive shared low
  logic           restore_dis; // go straight to float on release
  atsd_ratio_type ratio;       // bus to core clock ratio
  logic           retry_n;     // retry pin value
  logic           retry_oe;    // retry pin enable
  logic           shared_n;    // shared pin value
  logic           shared_oe;   // shared pin enable

  modport ctl (output start, neg, retry_val, shared_val, restore_dis,
               ratio, input retry_n, retry_oe, shared_n, shared_oe);
  modport drv (input start, neg, retry_val, shared_val, restore_dis,
               ratio, output retry_n, retry_oe, shared_n, shared_oe);
endinterface

`default_nettype wire

// File: hw/atsd_resp_drv.sv
`default_nettype none

// ------------------------------------------------------------------
// open-collector style driver for the retry and shared pins
// ------------------------------------------------------------------
module atsd_resp_drv
  import atsd_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  // control from the sequencer
  atsd_resp_if.drv  rsp
);

  atsd_drv_type     st_reg;   // phase of the pin driver
  logic [CNT_W-1:0] cnt_reg;  // cycles left in the current phase
  logic             rty_reg;  // this response includes retry
  logic             shd_reg;  // this response includes shared
  logic [CNT_W-1:0] drv_len;  // drive-high length for the ratio

  // drive-high length by clock ratio; fractions rounded to mclk
  always_comb begin
    case (rsp.ratio)
      ATSD_RATIO_1_1: drv_len = DRV_CYC_1_1;
      ATSD_RATIO_2_1: drv_len = DRV_CYC_2_1;
      ATSD_RATIO_3_1: drv_len = DRV_CYC_3_1;
      default:        drv_len = DRV_CYC_3_2;
    endcase
  end

  // phase sequencer: assert, float, drive high, float
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg  <= DRV_OFF;
      cnt_reg <= '0;
    end else if (ce) begin
      case (st_reg)
        DRV_OFF: begin
          if (rsp.start) st_reg <= DRV_ASRT;
        end
        DRV_ASRT: begin
          if (rsp.neg && rsp.restore_dis) begin
            st_reg <= DRV_OFF;
          end else if (rsp.neg) begin
            st_reg  <= DRV_FLOAT;
            cnt_reg <= FLOAT_CYC;
          end
        end
        DRV_FLOAT: begin
          // other drivers may still pull low; float before restoring
          if (cnt_reg == CNT_ONE) begin
            st_reg  <= DRV_HIGH;
            cnt_reg <= drv_len;
          end else begin
            cnt_reg <= cnt_reg - CNT_ONE;
          end
        end
        DRV_HIGH: begin
          if (cnt_reg == CNT_ONE) st_reg <= DRV_OFF;
          else cnt_reg <= cnt_reg - CNT_ONE;
        end
        default: st_reg <= DRV_OFF;
      endcase
    end
  end

  // which lines take part, latched when the response starts
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rty_reg <= 1'b0;
      shd_reg <= 1'b0;
    end else if (ce && st_reg == DRV_OFF && rsp.start) begin
      rty_reg <= rsp.retry_val;
      shd_reg <= rsp.shared_val;
    end
  end

  // pins: low while asserting, high while restoring
  assign rsp.retry_n   = (st_reg != DRV_ASRT);
  assign rsp.shared_n  = (st_reg != DRV_ASRT);
  assign rsp.retry_oe  = rty_reg && (st_reg == DRV_ASRT ||
                                     st_reg == DRV_HIGH);
  assign rsp.shared_oe = shd_reg && (st_reg == DRV_ASRT ||
                                     st_reg == DRV_HIGH);

endmodule

`default_nettype wire

// File: hw/atsd_core.sv
`default_nettype none

// Functional notes
// - ack sampled: float address next cycle
// - sample retry the cycle after ack
// - no ack: keep address and attributes driven
// - snoop retry asserted third cycle after start
// - push needed: request bus cycle after retry
// - negate retry second cycle after ack
// - release: float, drive high, float
// - config bit 7 skips drive-high step
// - own retry: drop request, abort data
// - foreign retry: drop request one bus cycle
// - shared follows retry timing
// - shared input picks allocation state
// - every non address-only start requests data
// - take data bus only on qualified grant
// - grant negated: hold data tenures
// - grant ignored until own transfer start
// - snoop only global, non-excluded transfers

module atsd_core
  import atsd_pkg::*;
(
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire logic            ce,
  input  wire logic            bus_tick,
  // configuration
  input  wire atsd_pkg::atsd_ratio_type ratio_sel,
  input  wire logic [atsd_pkg::CFG_W-1:0] hw_impl_config_reg,
  // own address tenure, from the core
  input  wire logic            own_ts_req,
  input  wire logic            own_addr_only,
  input  wire logic            core_br_req,
  input  wire logic            data_done,
  output logic                 addr_oe,
  output logic                 bus_request_out_n,
  output logic                 tenure_retry,
  output logic                 alloc_valid,
  output logic                 alloc_shared,
  output logic                 data_own,
  output logic                 data_abort,
  output logic                 data_active,
  // snoop lookup from the cache
  input  wire logic            snoop_excluded,
  input  wire logic            snoop_hit_retry,
  input  wire logic            snoop_hit_shared,
  input  wire logic            snoop_need_push,
  output logic                 snoop_start,
  // bus pins, active low
  input  wire logic            transfer_start_n,
  input  wire logic            ext_transfer_start_n,
  input  wire logic            global_attr_n,
  input  wire logic            addr_ack_in_n,
  input  wire logic            addr_retry_in_n,
  output logic                 addr_retry_out_n,
  output logic                 addr_retry_oe,
  input  wire logic            shared_resp_in_n,
  output logic                 shared_resp_out_n,
  output logic                 shared_resp_oe,
  input  wire logic            data_grant_in_n,
  input  wire logic            data_busy_in_n,
  input  wire logic            data_retry_in_n
);

  import atsd_pkg::*;

  // ----------------------------------------------------------------
  // sampled bus conditions
  // ----------------------------------------------------------------
  logic tick;       // bus clock edge, not frozen
  logic ts_seen;    // a transfer start on the bus
  logic addr_ack_in;       // address acknowledge asserted
  logic rtry;       // address retry asserted
  logic own_retry;  // retry taken against our own tenure
  logic fgn_retry;  // retry seen while not address master
  logic qual_grant; // qualified data bus grant

  // released lines pull up, so high reads as negated
  assign tick    = ce & bus_tick;
  assign ts_seen = !transfer_start_n | !ext_transfer_start_n;
  assign addr_ack_in    = !addr_ack_in_n;
  assign rtry    = !addr_retry_in_n;

  // ----------------------------------------------------------------
  // own address tenure
  // ----------------------------------------------------------------
  atsd_own_type own_reg;      // address master phase
  logic         addr_oe_reg;  // address and attributes driven
  logic         aonly_reg;    // current tenure is address only

  assign own_retry = tick && own_reg == OWN_RTY && rtry;
  assign fgn_retry = tick && own_reg == OWN_IDLE && rtry;

  // phase: wait for ack, then one retry window cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      own_reg <= OWN_IDLE;
    end else if (tick) begin
      case (own_reg)
        OWN_IDLE: if (own_ts_req) own_reg <= OWN_ADDR;
        OWN_ADDR: if (addr_ack_in) own_reg <= OWN_RTY;
        OWN_RTY:  own_reg <= OWN_IDLE;
        default:  own_reg <= OWN_IDLE;
      endcase
    end
  end

  // address drive: held until ack, floated the cycle after it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_oe_reg <= 1'b0;
      aonly_reg   <= 1'b0;
    end else if (tick) begin
      if (own_reg == OWN_IDLE && own_ts_req) begin
        addr_oe_reg <= 1'b1;
        aonly_reg   <= own_addr_only;
      end else if (own_reg == OWN_ADDR && addr_ack_in) begin
        addr_oe_reg <= 1'b0;
      end
    end
  end
  assign addr_oe = addr_oe_reg;

  // ----------------------------------------------------------------
  // outcome of the retry window
  // ----------------------------------------------------------------
  logic retry_reg;   // one-cycle pulse: tenure must be retried
  logic alloc_v_reg; // one-cycle pulse: allocation state valid
  logic alloc_s_reg; // incoming block is shared-unmodified

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      retry_reg   <= 1'b0;
      alloc_v_reg <= 1'b0;
      alloc_s_reg <= 1'b0;
    end else if (ce) begin
      retry_reg   <= own_retry;
      alloc_v_reg <= tick && own_reg == OWN_RTY && !rtry && !aonly_reg;
      if (tick && own_reg == OWN_RTY && !rtry)
        alloc_s_reg <= !shared_resp_in_n;
    end
  end
  assign tenure_retry = retry_reg;
  assign alloc_valid  = alloc_v_reg;
  assign alloc_shared = alloc_s_reg;

  // ----------------------------------------------------------------
  // data bus qualification
  // ----------------------------------------------------------------
  logic pend_reg;  // data tenure waiting for grant
  logic own_reg_d; // one-cycle pulse: data bus taken
  logic act_reg;   // data tenure in progress
  logic abort_reg; // one-cycle pulse: data tenure aborted

  // grant counts only once a start of ours has asked for data
  assign qual_grant = tick && pend_reg && !data_grant_in_n &&
                      data_busy_in_n && data_retry_in_n &&
                      !(own_reg == OWN_RTY && rtry);

  // pending data request raised by the start itself
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pend_reg <= 1'b0;
    end else if (tick) begin
      if (own_reg == OWN_IDLE && own_ts_req && !own_addr_only)
        pend_reg <= 1'b1;
      else if (qual_grant || own_retry)
        pend_reg <= 1'b0;
    end
  end

  // ownership and abort; abort wins even with burst data in
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      own_reg_d <= 1'b0;
      act_reg   <= 1'b0;
      abort_reg <= 1'b0;
    end else if (ce) begin
      own_reg_d <= qual_grant;
      abort_reg <= own_retry && act_reg;
      // a new grant wins over the end of the previous tenure
      if (qual_grant) act_reg <= 1'b1;
      else if (own_retry || data_done) act_reg <= 1'b0;
    end
  end
  assign data_own    = own_reg_d;
  assign data_abort  = abort_reg;
  assign data_active = act_reg;

  // ----------------------------------------------------------------
  // snoop response sequencing
  // ----------------------------------------------------------------
  logic             sn_act_reg;  // a snoop response window is open
  logic [CNT_W-1:0] sn_cnt_reg;  // bus cycles since transfer start
  logic             ak_seen_reg; // ack seen for the snooped tenure
  logic [CNT_W-1:0] ak_cnt_reg;  // bus cycles since that ack
  logic             resp_on_reg; // response pins are being driven
  logic             push_reg;    // bus request for the push
  logic             snoop_go;    // accept a new snoop
  logic             sn_assert;   // drive the response this edge
  logic             sn_release;  // start the release this edge

  // own tenures are not snooped; only global, ordinary transfers
  assign snoop_go  = tick && ts_seen && !global_attr_n &&
                     !snoop_excluded && !own_ts_req && !sn_act_reg;
  assign sn_release = tick && sn_act_reg && ak_seen_reg &&
                      ak_cnt_reg == RTY_NEG_CYC;
  assign sn_assert = tick && sn_act_reg && !resp_on_reg &&
                     !sn_release && sn_cnt_reg == RTY_ASSERT_CYC &&
                     (snoop_hit_retry || snoop_hit_shared);
  assign snoop_start = snoop_go;

  // bus-cycle counters from start and from ack
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sn_act_reg  <= 1'b0;
      sn_cnt_reg  <= '0;
      ak_seen_reg <= 1'b0;
      ak_cnt_reg  <= '0;
    end else if (snoop_go) begin
      sn_act_reg  <= 1'b1;
      sn_cnt_reg  <= CNT_ONE;
      ak_seen_reg <= 1'b0;
    end else if (sn_release) begin
      sn_act_reg  <= 1'b0;
      ak_seen_reg <= 1'b0;
    end else if (tick && sn_act_reg) begin
      // saturate so a slow ack cannot wrap the start counter
      if (sn_cnt_reg != RTY_ASSERT_CYC) sn_cnt_reg <= sn_cnt_reg + CNT_ONE;
      if (ak_seen_reg) begin
        ak_cnt_reg <= ak_cnt_reg + CNT_ONE;
      end else if (addr_ack_in) begin
        ak_seen_reg <= 1'b1;
        ak_cnt_reg  <= CNT_ONE;
      end
    end
  end

  // response drive flag and the push request behind it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      resp_on_reg <= 1'b0;
      push_reg    <= 1'b0;
    end else if (tick) begin
      if (sn_assert) resp_on_reg <= 1'b1;
      else if (sn_release) resp_on_reg <= 1'b0;
      // raised on the assert tick so the request shows one bus cycle
      // after the retry pin goes low
      if (sn_assert && snoop_hit_retry && snoop_need_push)
        push_reg <= 1'b1;
      else if (own_reg == OWN_IDLE && own_ts_req) push_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // bus request
  // ----------------------------------------------------------------
  logic br_reg; // registered request, low for a bus cycle on retry

  // our own pushing retry is seen on the wired line as well and must
  // not cancel the push request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) br_reg <= 1'b0;
    else if (tick)
      br_reg <= (core_br_req || push_reg) && !own_retry &&
                !(fgn_retry && !push_reg);
  end
  // own retry drops the request in the same cycle, not a cycle late
  assign bus_request_out_n = !(br_reg && !(own_reg == OWN_RTY && rtry));

  // ----------------------------------------------------------------
  // response pin driver
  // ----------------------------------------------------------------
  atsd_resp_if rsp ();

  assign rsp.start       = sn_assert && ce;
  assign rsp.neg         = sn_release && resp_on_reg;
  assign rsp.retry_val   = snoop_hit_retry;
  assign rsp.shared_val  = snoop_hit_shared ||
                           (snoop_hit_retry && snoop_need_push);
  assign rsp.restore_dis = hw_impl_config_reg[RESTORE_DIS_BIT];
  assign rsp.ratio       = ratio_sel;

  atsd_resp_drv u_drv (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .rsp  (rsp.drv)
  );

  assign addr_retry_out_n  = rsp.retry_n;
  assign addr_retry_oe     = rsp.retry_oe;
  assign shared_resp_out_n = rsp.shared_n;
  assign shared_resp_oe    = rsp.shared_oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_ack_in_addr;
    tick && own_reg == OWN_ADDR && addr_ack_in;
  endsequence

  property p_addr_float;
    @(posedge mclk) disable iff (rst)
      s_ack_in_addr |=> !addr_oe;
  endproperty
  a_addr_float: assert property (p_addr_float)
    else $error("address still driven after ack");

  property p_rty_window;
    @(posedge mclk) disable iff (rst)
      s_ack_in_addr |=> own_reg == OWN_RTY;
  endproperty
  a_rty_window: assert property (p_rty_window)
    else $error("retry window not opened after ack");

  property p_addr_hold;
    @(posedge mclk) disable iff (rst)
      (own_reg == OWN_ADDR && !addr_ack_in) |=> addr_oe;
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address released without ack");

  property p_retry_drop;
    @(posedge mclk) disable iff (rst)
      own_retry |-> bus_request_out_n ##1 tenure_retry && !pend_reg;
  endproperty
  a_retry_drop: assert property (p_retry_drop)
    else $error("own retry did not drop request");

  property p_fgn_hold;
    @(posedge mclk) disable iff (rst)
      fgn_retry && !push_reg |=> bus_request_out_n;
  endproperty
  a_fgn_hold: assert property (p_fgn_hold)
    else $error("request not dropped after foreign retry");

  property p_qual;
    @(posedge mclk) disable iff (rst)
      $rose(data_own) |-> $past(!data_grant_in_n) &&
        $past(data_busy_in_n) && $past(data_retry_in_n) &&
        $past(pend_reg);
  endproperty
  a_qual: assert property (p_qual)
    else $error("data bus taken on unqualified grant");

  property p_snoop_global;
    @(posedge mclk) disable iff (rst)
      snoop_start |-> !global_attr_n && !snoop_excluded;
  endproperty
  a_snoop_global: assert property (p_snoop_global)
    else $error("snoop started on a non-global transfer");

  logic addr_retry_n_high_or_off; // pin never driven low after release
  assign addr_retry_n_high_or_off = !addr_retry_oe || addr_retry_out_n;

  sequence s_release_go;
    rsp.neg && !rsp.restore_dis && ce;
  endsequence

  property p_release;
    @(posedge mclk) disable iff (rst)
      s_release_go ##1 ce |=> addr_retry_n_high_or_off;
  endproperty

  a_release: assert property (p_release)
    else $error("retry driven low during release");

  property p_assert_cnt;
    @(posedge mclk) disable iff (rst)
      sn_assert |=> !addr_retry_out_n &&
                    (addr_retry_oe || shared_resp_oe);
  endproperty
  a_assert_cnt: assert property (p_assert_cnt)
    else $error("snoop response not driven after assert tick");

endmodule

`default_nettype wire

// File: bench/atsd_far_model.sv
`default_nettype none

// ----------------------------------------------------------
// far side: address arbiter and foreign snoopers
// ----------------------------------------------------------
module atsd_far_model (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // tenure seen and wanted answers
  input  wire logic       ten,
  input  wire logic       want_rty,
  input  wire logic       want_shd,
  input  wire logic [1:0] ack_dly,
  // line drives: ack_n active low, rty_drv and shd_drv high pull the wire low
  output logic            ack_n,
  output logic            rty_drv,
  output logic            shd_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_reg;  // cycles waited on this tenure
  logic       sent_reg; // ack already given
  // slow or prompt ack, answers only in the cycle after ack
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {ack_n, rty_drv, shd_drv} <= 3'h4;
      {cnt_reg, sent_reg} <= 3'h0;
    end else begin
      ack_n <= 1'h1;
      rty_drv <= !ack_n && want_rty;
      shd_drv <= !ack_n && want_shd;
      if (!ten) begin
        {cnt_reg, sent_reg} <= 3'h0;
      end else if (!sent_reg && cnt_reg == ack_dly) begin
        ack_n <= 1'h0;
        sent_reg <= 1'h1;
      end else if (!sent_reg) begin
        cnt_reg <= cnt_reg + 2'h1;
      end
    end
  end
endmodule

`default_nettype wire

// File: bench/tb.sv
`default_nettype none

module tb;
  import atsd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------
  // stimulus, 1:1 bus so every mclk is a bus edge
  // ----------------------------------------------------------
  logic mclk = '0, rst = '1, ce = '1, bus_tick = '1;
  atsd_ratio_type ratio_sel = ATSD_RATIO_1_1;
  logic [CFG_W-1:0] hw_impl_config_reg = '0;
  logic own_ts_req = '0, own_addr_only = '0, core_br_req = '1;
  logic data_done = '0, snoop_excluded = '0, snoop_need_push = '0;
  logic snoop_hit_retry = '0, snoop_hit_shared = '0;
  logic transfer_start_n = '1, ext_transfer_start_n = '1;
  logic global_attr_n = '1, data_grant_in_n = '1;
  logic data_busy_in_n = '1, data_retry_in_n = '1;
  logic addr_oe, bus_request_out_n, tenure_retry, alloc_valid;
  logic alloc_shared, data_own, data_abort, data_active, snoop_start;
  logic addr_retry_out_n, addr_retry_oe, shared_resp_out_n;
  logic shared_resp_oe, addr_ack_in_n, rty_drv, shd_drv;
  logic frt = '0, frn = '0, want_rty = '0, want_shd = '0;
  logic [1:0] ack_dly = '0;
  logic [2:0] q[$]; // expected result pulses, oldest first
  logic [2:0] got;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  // pulled-up shared lines, low if any party pulls
  wire addr_retry_in_n = !((addr_retry_oe && !addr_retry_out_n) ||
                           rty_drv || frt);
  wire shared_resp_in_n = !((shared_resp_oe && !shared_resp_out_n) ||
                            shd_drv);
  initial begin
    forever #10 mclk = !mclk;
  end
  atsd_core i_atsd_core (.*);
  atsd_far_model i_atsd_far_model (.mclk, .rst, .ten(addr_oe || frn),
    .want_rty, .want_shd, .ack_dly, .ack_n(addr_ack_in_n), .rty_drv,
    .shd_drv);
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [2:0] g, input logic [2:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    chk(q.size() != 0, 0);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watcher: each result pulse is matched to the oldest note
  always @(posedge mclk) begin
    if (!rst && (tenure_retry || alloc_valid || data_own)) begin
      got = tenure_retry ? 3'h4 : data_own ? 3'h6 : {2'h1, alloc_shared};
      chk(got, q.size() == 0 ? 3'h7 : q.pop_front());
    end
  end
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 3000) begin
      chk(1, 0);
      summarize;
    end
  end
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic own(input logic rt, input logic sh, input logic ao,
                     input logic eg);
    logic ea;
    ea = eg && !ao;
    {want_rty, want_shd, own_addr_only} = {rt, sh, ao};
    ack_dly = 2'($urandom_range(3));
    own_ts_req = 1;
    tick;
    own_ts_req = 0;
    data_grant_in_n = !eg; // early grant, before the ack
    if (ea) q.push_back(3'h6);
    tick;
    data_grant_in_n = 1;
    chk(addr_oe, 1);
    for (int n = 0; n < 9 && addr_ack_in_n; n++) tick;
    if (rt) q.push_back(3'h4);
    else if (!ao) q.push_back({2'h1, sh});
    tick;
    if (rt) chk(bus_request_out_n, 1);
    tick;
    chk(addr_oe, 0);
    chk({data_abort, data_active}, {ea && rt, ea && !rt});
    tick(2);
    if (!rt && !ao && !eg) q.push_back(3'h6);
    {data_busy_in_n, data_grant_in_n} = 2'h0;
    tick;
    data_busy_in_n = 1; // busy cycle is refused
    tick;
    data_grant_in_n = 1;
    tick(3);
    data_done = 1;
    tick;
    data_done = 0;
  endtask
  task automatic snoop(input logic dis);
    int hi = 0;
    hw_impl_config_reg[RESTORE_DIS_BIT] = dis;
    {snoop_hit_retry, snoop_hit_shared, global_attr_n} = 3'h6;
    {snoop_need_push, core_br_req} = {!dis, 1'b0}; // push only if dis=0
    {ack_dly, want_rty, want_shd} = 4'h0;
    if (dis) ext_transfer_start_n = 0;
    else transfer_start_n = 0;
    tick;
    {transfer_start_n, ext_transfer_start_n, global_attr_n} = 3'h7;
    tick;
    chk(addr_retry_oe, 0);
    tick(2);
    chk(addr_retry_oe, 1);
    frn = 1;
    for (int n = 0; n < 9 && addr_ack_in_n; n++) tick;
    chk(bus_request_out_n, dis);
    frn = 0;
    tick;
    for (int n = 1; n < 8; n++) begin
      tick;
      if (n < 2) chk({addr_retry_oe, addr_retry_out_n}, 2);
      chk(shared_resp_oe, addr_retry_oe);
      hi += addr_retry_oe && addr_retry_out_n;
    end
    chk(hi, dis ? 0 : DRV_CYC_1_1);
    chk(addr_retry_oe, 0);
    {snoop_hit_retry, snoop_hit_shared, snoop_need_push, core_br_req} = 4'h1;
  endtask
  initial begin
    void'($urandom(26));
    tick(16);
    rst = 0;
    tick(2);
    data_grant_in_n = 0;
    tick(2);
    {data_grant_in_n, frt} = 2'h3;
    tick;
    frt = 0;
    chk(bus_request_out_n, 1);
    tick;
    chk(bus_request_out_n, 0);
    snoop(1);
    snoop(0);
    repeat (12) own(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
    tick(4);
    summarize;
  end
endmodule

`default_nettype wire
